// ==== baai_regs.svh ====
// address map, field positions and timing constants of the bus-addressed converter interface
`ifndef BAAI_REGS_SVH
`define BAAI_REGS_SVH

// =====================================================================
// bus address map
`define BAAI_CH_BASE        16'h2080
`define BAAI_RAM_BASE       16'h2100
`define BAAI_RAM_LAST       16'h217F
`define BAAI_RAM_RES_BASE   7'h00
`define BAAI_CH_COUNT       8
`define BAAI_CH_MAX         16

// =====================================================================
// result byte layout
`define BAAI_HI_SIGN_BIT    7
`define BAAI_MAG_BITS       10

// =====================================================================
// conversion sequence steps (step 0 resolves sign, 1..10 magnitude msb first)
`define BAAI_STEP_HI_READY  4'h3
`define BAAI_STEP_LAST      4'hA

// =====================================================================
// timing
`define BAAI_CLK_MHZ        200
`define BAAI_CONV_NOM_US    55
`define BAAI_CONV_MAX_US    100
`define BAAI_TIMEOUT_CYC    (`BAAI_CONV_MAX_US * `BAAI_CLK_MHZ)

`endif

// ==== baai_pkg.sv ====
// types shared by the converter interface modules
package baai_pkg;
    typedef enum logic [1:0] {
        BAAI_IDLE,
        BAAI_WAIT_HI,
        BAAI_WAIT_LO
    } baai_bus_st_t;
endpackage

// ==== baai_ram.sv ====
// on-card result memory: one write port, combinational read port
`timescale 1ns/1ps
`include "baai_regs.svh"

module baai_ram #(
    parameter int DEPTH = 128,
    parameter int AW    = 7
) (
    input  wire logic          clock,
    input  wire logic          ce,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [7:0]    wr_data,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [7:0]    rd_data
);
    logic [7:0] mem [DEPTH];

    // =====================================================================
    // storage
    // write only while the clock enable lets state move
    always_ff @(posedge clock) begin
        if (ce && wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // read path feeds the bus data register of the top
    assign rd_data = mem[rd_addr];
endmodule // baai_ram

// ==== baai_adc_if.sv ====
// bus-addressed multichannel successive-approximation converter interface
// Behaviour
// RULE_01 - eight analog channels by number, decode extendable to sixteen
// RULE_02 - result is ten magnitude bits plus a sign bit
// RULE_03 - result reaches the processor under 100 us after the selecting read
// RULE_04 - every channel sits at its own fixed bus address, decoded directly
// RULE_05 - a read of a channel address selects that input and starts conversion
// RULE_06 - processor waits during conversion, then result is driven onto data bus
// RULE_07 - result moves as two bytes from two consecutive channel addresses
// RULE_08 - first byte carries the two top bits while lower bits still resolve
// RULE_09 - once settled, the lower eight bits come as the second byte
// RULE_10 - converter clock is asynchronous; bus side tolerates its timebase
// RULE_11 - bits resolve one per converter clock in a fixed order
// RULE_12 - both result bytes are also written to fixed per-channel card memory; an access-bound stop before step 3 writes only the lower byte
// RULE_13 - channel read strobes conversion start and holds the multiplexer latched
// RULE_14 - conversion completes roughly 55 us after the starting read
// RULE_15 - early second-byte read is held off until the lower bits complete
`timescale 1ns/1ps
`include "baai_regs.svh"

module baai_adc_if #(
    parameter int CH_COUNT    = `BAAI_CH_COUNT,
    parameter int TIMEOUT_CYC = `BAAI_TIMEOUT_CYC,
    parameter int TW          = $clog2(TIMEOUT_CYC + 1)
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic [15:0] bus_addr,
    input  wire logic        bus_rd,
    input  wire logic        conv_clk_pin,
    input  wire logic        comp_pin,
    output logic      [7:0]  bus_data_r,
    output logic             bus_ack_r,
    output logic             bus_wait_r,
    output logic      [3:0]  mux_sel_r,
    output logic             soc_r,
    output logic      [9:0]  dac_mag_r,
    output logic             dac_neg_r,
    output logic             conv_busy_r
);
    localparam logic [15:0] CH_END = 16'(`BAAI_CH_BASE + 2 * CH_COUNT);
    localparam int          MAGW   = `BAAI_MAG_BITS;

    // one-hot trial bit for magnitude position idx
    function automatic logic [9:0] trial_bit(input logic [3:0] idx);
        trial_bit = 10'(10'h001 << idx);
    endfunction

    // =====================================================================
    // pin synchronisers
    logic cclk_s1_r, cclk_s2_r, cclk_s3_r, comp_s1_r, comp_s2_r;
    logic cedge;
    // two flops on each pin; third flop only for the edge detector
    always_ff @(posedge clock) begin
        if (rst) begin
            cclk_s1_r <= 1'b0;
            cclk_s2_r <= 1'b0;
            cclk_s3_r <= 1'b0;
            comp_s1_r <= 1'b0;
            comp_s2_r <= 1'b0;
        end else if (ce) begin
            cclk_s1_r <= conv_clk_pin;
            cclk_s2_r <= cclk_s1_r;
            cclk_s3_r <= cclk_s2_r;
            comp_s1_r <= comp_pin;
            comp_s2_r <= comp_s1_r;
        end
    end
    assign cedge = cclk_s2_r & ~cclk_s3_r; // RULE_10

    // =====================================================================
    // conversion sequencer
    logic [3:0]    step_r, step_nxt;
    logic [9:0]    mag_r, mag_nxt, dac_mag_nxt;
    logic          sign_r, sign_nxt, dac_neg_nxt, busy_nxt, soc_nxt;
    logic          hi_ok_r, hi_ok_nxt;
    logic [TW-1:0] tmo_r, tmo_nxt;
    logic [3:0]    idx;
    logic          keep, start, hi_wr, lo_wr;
    logic [7:0]    hi_byte, lo_byte;

    assign hi_byte = {sign_r, 5'h00, mag_r[9:8]};   // RULE_02
    assign lo_byte = mag_r[7:0];

    // one result bit (sign first, then magnitude) decided per synchronised converter clock edge
    always_comb begin
        step_nxt    = step_r;
        mag_nxt     = mag_r;
        sign_nxt    = sign_r;
        dac_mag_nxt = dac_mag_r;
        dac_neg_nxt = dac_neg_r;
        busy_nxt    = conv_busy_r;
        hi_ok_nxt   = hi_ok_r;
        tmo_nxt     = tmo_r;
        soc_nxt     = 1'b0;
        hi_wr       = 1'b0;
        lo_wr       = 1'b0;
        idx         = 4'(MAGW) - step_r;
        keep        = comp_s2_r ^ sign_r; // kept when |input| is above the trial
        if (start) begin
            // restart: clear result, strobe start of conversion
            step_nxt    = 4'h0;
            mag_nxt     = 10'h000;
            sign_nxt    = 1'b0;
            dac_mag_nxt = 10'h000;
            dac_neg_nxt = 1'b0;
            busy_nxt    = 1'b1;
            hi_ok_nxt   = 1'b0;
            tmo_nxt     = '0;
            soc_nxt     = 1'b1; // RULE_13 RULE_05
        end else if (conv_busy_r) begin
            tmo_nxt = TW'(tmo_r + 1'b1);
            if (cedge) begin // RULE_11
                if (step_r == 4'h0) begin
                    sign_nxt    = ~comp_s2_r;
                    dac_neg_nxt = ~comp_s2_r;
                    dac_mag_nxt = trial_bit(4'h9);
                    step_nxt    = 4'h1;
                end else begin
                    mag_nxt[idx]        = keep;
                    step_nxt            = step_r + 4'h1;
                    if (step_r == `BAAI_STEP_LAST) begin
                        busy_nxt = 1'b0; // RULE_14
                        lo_wr    = 1'b1; // RULE_12
                    end else begin
                        dac_mag_nxt = mag_nxt | trial_bit(idx - 4'h1);
                    end
                    if (step_nxt == `BAAI_STEP_HI_READY) begin
                        hi_ok_nxt = 1'b1; // RULE_08
                        hi_wr     = 1'b1; // RULE_12
                    end
                end
            end
            // a stalled converter clock cannot exceed the access-time bound
            if (tmo_r == TW'(TIMEOUT_CYC - 1)) begin
                busy_nxt  = 1'b0; // RULE_03
                hi_ok_nxt = 1'b1;
                lo_wr     = 1'b1;
                tmo_nxt   = tmo_r; // count stops at the bound
                step_nxt  = `BAAI_STEP_LAST;
            end
        end
    end

    // sequencer registers
    always_ff @(posedge clock) begin
        if (rst) begin
            step_r      <= 4'h0;
            mag_r       <= 10'h000;
            sign_r      <= 1'b0;
            dac_mag_r   <= 10'h000;
            dac_neg_r   <= 1'b0;
            conv_busy_r <= 1'b0;
            hi_ok_r     <= 1'b0;
            tmo_r       <= '0;
            soc_r       <= 1'b0;
        end else if (ce) begin
            step_r      <= step_nxt;
            mag_r       <= mag_nxt;
            sign_r      <= sign_nxt;
            dac_mag_r   <= dac_mag_nxt;
            dac_neg_r   <= dac_neg_nxt;
            conv_busy_r <= busy_nxt;
            hi_ok_r     <= hi_ok_nxt;
            tmo_r       <= tmo_nxt;
            soc_r       <= soc_nxt;
        end
    end

    // =====================================================================
    // card memory
    logic [6:0] ram_wr_addr;
    logic [7:0] ram_wr_data, ram_rd_data;

    // fixed pair of bytes per channel: even holds top byte, odd the lower byte
    assign ram_wr_addr = 7'(`BAAI_RAM_RES_BASE + {mux_sel_r, 1'b0} + {6'h00, lo_wr}); // RULE_12
    assign ram_wr_data = lo_wr ? mag_nxt[7:0] : {sign_nxt, 5'h00, mag_nxt[9:8]}; // includes the bit resolved now

    baai_ram u_ram (
        .clock   (clock),
        .ce      (ce),
        .wr_en   (hi_wr | lo_wr),
        .wr_addr (ram_wr_addr),
        .wr_data (ram_wr_data),
        .rd_addr (bus_addr[6:0]),
        .rd_data (ram_rd_data)
    );

    // =====================================================================
    // processor bus slave
    baai_pkg::baai_bus_st_t st_r, st_nxt;
    logic [7:0] data_nxt;
    logic [3:0] mux_nxt, ch;
    logic       ack_nxt, wait_nxt, is_ch, is_ram, take;

    assign ch     = bus_addr[4:1];
    assign is_ch  = (bus_addr >= `BAAI_CH_BASE) && (bus_addr < CH_END); // RULE_04 RULE_01
    assign is_ram = (bus_addr >= `BAAI_RAM_BASE) && (bus_addr <= `BAAI_RAM_LAST);
    assign take   = bus_rd && !bus_ack_r && (st_r == baai_pkg::BAAI_IDLE);
    assign start  = take && is_ch && !bus_addr[0]; // RULE_05

    // address decode, hold-off and byte delivery
    always_comb begin
        st_nxt   = st_r;
        data_nxt = bus_data_r;
        mux_nxt  = mux_sel_r;
        ack_nxt  = 1'b0;
        wait_nxt = bus_wait_r;
        case (st_r)
            baai_pkg::BAAI_IDLE: begin
                if (take && is_ch && !bus_addr[0]) begin
                    mux_nxt  = ch; // RULE_13
                    wait_nxt = 1'b1; // RULE_06
                    st_nxt   = baai_pkg::BAAI_WAIT_HI;
                end else if (take && is_ch && conv_busy_r && ch == mux_sel_r) begin
                    wait_nxt = 1'b1; // RULE_15
                    st_nxt   = baai_pkg::BAAI_WAIT_LO;
                end else if (take && is_ch) begin
                    data_nxt = lo_byte; // RULE_07
                    ack_nxt  = 1'b1;
                end else if (take && is_ram) begin
                    data_nxt = ram_rd_data;
                    ack_nxt  = 1'b1;
                end
            end
            baai_pkg::BAAI_WAIT_HI: begin
                if (hi_ok_r) begin
                    data_nxt = hi_byte; // RULE_08
                    ack_nxt  = 1'b1;
                    wait_nxt = 1'b0;
                    st_nxt   = baai_pkg::BAAI_IDLE;
                end
            end
            baai_pkg::BAAI_WAIT_LO: begin
                if (!conv_busy_r) begin
                    data_nxt = lo_byte; // RULE_09 RULE_15
                    ack_nxt  = 1'b1;
                    wait_nxt = 1'b0;
                    st_nxt   = baai_pkg::BAAI_IDLE;
                end
            end
            default: begin
                st_nxt   = baai_pkg::BAAI_IDLE;
                wait_nxt = 1'b0;
            end
        endcase
    end

    // bus registers
    always_ff @(posedge clock) begin
        if (rst) begin
            st_r       <= baai_pkg::BAAI_IDLE;
            bus_data_r <= 8'h00;
            bus_ack_r  <= 1'b0;
            bus_wait_r <= 1'b0;
            mux_sel_r  <= 4'h0;
        end else if (ce) begin
            st_r       <= st_nxt;
            bus_data_r <= data_nxt;
            bus_ack_r  <= ack_nxt;
            bus_wait_r <= wait_nxt;
            mux_sel_r  <= mux_nxt;
        end
    end

    // =====================================================================
    // checks
    soc_pulse_a: assert property (@(posedge clock) disable iff (rst) (ce && soc_r) |=> !soc_r) // RULE_13
        else $error("start strobe longer than one cycle");
    mux_hold_a: assert property (@(posedge clock) disable iff (rst) (ce && conv_busy_r && !start) |=> $stable(mux_sel_r)) // RULE_13
        else $error("multiplexer moved during conversion");
    mux_range_a: assert property (@(posedge clock) disable iff (rst) int'(mux_sel_r) < CH_COUNT) // RULE_01
        else $error("channel select out of range");
    ack_pulse_a: assert property (@(posedge clock) disable iff (rst) (ce && bus_ack_r) |=> !bus_ack_r) // RULE_06
        else $error("acknowledge longer than one cycle");
    wait_end_a: assert property (@(posedge clock) disable iff (rst) $fell(bus_wait_r) |-> bus_ack_r) // RULE_06
        else $error("wait released without data");
    time_bound_a: assert property (@(posedge clock) disable iff (rst) tmo_r < TW'(TIMEOUT_CYC)) // RULE_03
        else $error("conversion exceeded access bound");
    step_order_a: assert property (@(posedge clock) disable iff (rst)
        (ce && !start && cedge && conv_busy_r && step_r != `BAAI_STEP_LAST && tmo_r != TW'(TIMEOUT_CYC - 1))
        |=> step_r == 4'($past(step_r) + 4'h1)) // RULE_11
        else $error("conversion step skipped");
    hi_byte_a: assert property (@(posedge clock) disable iff (rst)
        (ce && st_r == baai_pkg::BAAI_WAIT_HI && hi_ok_r)
        |=> bus_ack_r && bus_data_r[1:0] == $past(mag_r[9:8]) && bus_data_r[7] == $past(sign_r)) // RULE_08
        else $error("first byte wrong");
    lo_hold_a: assert property (@(posedge clock) disable iff (rst)
        (ce && st_r == baai_pkg::BAAI_WAIT_LO && conv_busy_r) |=> !bus_ack_r) // RULE_15
        else $error("second byte given before completion");
endmodule // baai_adc_if

// ==== baai_front_model.sv ====
// converter front end model: channel voltages, comparator and bit clock
`timescale 1ns/1ps

module baai_front_model (
    input  wire logic             conv_busy,
    input  wire logic             clk_stop,
    input  wire logic [3:0]       mux_sel,
    input  wire logic [9:0]       dac_mag,
    input  wire logic             dac_neg,
    input  wire logic [15:0]      ch_neg,
    input  wire logic [15:0][9:0] ch_mag,
    output logic                  conv_clk_pin,
    output logic                  comp_pin
);
    int a2;
    int d2;

    // =====================================================================
    // bit clock
    // free-running phase against the bus clock, held low between conversions
    initial conv_clk_pin = 1'b0;
    always begin
        #31.5;
        conv_clk_pin = (conv_busy && !clk_stop) ? ~conv_clk_pin : 1'b0;
    end

    // =====================================================================
    // comparator
    // selected input sits half a step off the grid so no trial ever ties
    always_comb begin
        a2 = 2 * int'(ch_mag[mux_sel]) + 1;
        if (ch_neg[mux_sel]) a2 = -a2;
        d2 = dac_neg ? -2 * int'(dac_mag) : 2 * int'(dac_mag);
        comp_pin = (a2 > d2);
    end
endmodule // baai_front_model

// ==== bus_addressed_multichannel_adc_interface_bench.sv ====
// self-checking bench for the bus-addressed converter interface
`timescale 1ns/1ps

module bus_addressed_multichannel_adc_interface_bench;
    localparam int TO_CYC = 400;
    logic             clock = 1'b0;
    logic             rst = 1'b1;
    logic             ce = 1'b1;
    logic [15:0]      bus_addr = 16'h0000;
    logic             bus_rd = 1'b0;
    logic             conv_clk_pin;
    logic             comp_pin;
    logic             clk_stop = 1'b0;
    logic [7:0]       bus_data_r;
    logic             bus_ack_r;
    logic             bus_wait_r;
    logic [3:0]       mux_sel_r;
    logic             soc_r;
    logic [9:0]       dac_mag_r;
    logic             dac_neg_r;
    logic             conv_busy_r;
    logic [15:0]      ch_neg = 16'h0000;
    logic [15:0][9:0] ch_mag = '0;
    logic [9:0]       mags [8] = '{10'h3FF, 10'h000, 10'h155, 10'h2AA, 10'h001, 10'h200, 10'h0FF, 10'h100};
    logic [7:0]       rd_data;
    logic             rd_wait;
    logic             rd_ack;
    int               rd_lat;
    int               soc_cnt = 0;
    int               errors = 0;
    int               checks = 0;

    baai_adc_if #(
        .CH_COUNT    (8),
        .TIMEOUT_CYC (TO_CYC)
    ) dut_u (
        .clock        (clock),
        .rst          (rst),
        .ce           (ce),
        .bus_addr     (bus_addr),
        .bus_rd       (bus_rd),
        .conv_clk_pin (conv_clk_pin),
        .comp_pin     (comp_pin),
        .bus_data_r   (bus_data_r),
        .bus_ack_r    (bus_ack_r),
        .bus_wait_r   (bus_wait_r),
        .mux_sel_r    (mux_sel_r),
        .soc_r        (soc_r),
        .dac_mag_r    (dac_mag_r),
        .dac_neg_r    (dac_neg_r),
        .conv_busy_r  (conv_busy_r)
    );

    baai_front_model model_u (
        .conv_busy    (conv_busy_r),
        .clk_stop     (clk_stop),
        .mux_sel      (mux_sel_r),
        .dac_mag      (dac_mag_r),
        .dac_neg      (dac_neg_r),
        .ch_neg       (ch_neg),
        .ch_mag       (ch_mag),
        .conv_clk_pin (conv_clk_pin),
        .comp_pin     (comp_pin)
    );

    // =====================================================================
    // clock and start pulse counter
    always #2.5 clock = ~clock;
    always @(negedge clock) begin
        if (soc_r === 1'b1) soc_cnt++;
    end

    // =====================================================================
    // shared tasks
    // compare and count
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one read cycle: hold request until one edge past the answering edge, then drop
    task automatic bus_read(input logic [15:0] addr, input int lim);
        rd_wait = 1'b0;
        rd_lat = 0;
        @(posedge clock);
        #1;
        bus_addr = addr;
        bus_rd = 1'b1;
        while (bus_ack_r !== 1'b1 && rd_lat < lim) begin
            @(posedge clock);
            #1;
            rd_lat++;
            if (bus_wait_r === 1'b1) rd_wait = 1'b1;
        end
        rd_ack = (bus_ack_r === 1'b1);
        rd_data = bus_data_r;
        if (rd_ack) begin
            @(posedge clock);
            #1;
        end
        bus_rd = 1'b0;
    endtask

    // =====================================================================
    // scenarios
    // pipelined two-byte conversion of one channel
    task automatic test_conv(input int ch);
        int s0;
        int lat;
        s0 = soc_cnt;
        ch_neg[ch] = ch[0];
        ch_mag[ch] = mags[ch];
        bus_read(16'h2080 + 16'(2 * ch), TO_CYC);
        lat = rd_lat;
        chk("hi byte", {ch[0], 5'h00, mags[ch][9:8]}, rd_data);
        chk("hi wait", 1'b1, rd_wait);
        chk("busy at hi", 1'b1, conv_busy_r);
        chk("channel", 16'(ch), mux_sel_r);
        chk("start pulses", 16'(s0 + 1), 16'(soc_cnt));
        bus_read(16'h2081 + 16'(2 * ch), TO_CYC);
        chk("lo byte", mags[ch][7:0], rd_data);
        chk("lo held off", 1'b1, rd_wait);
        chk("in time", 1'b1, lat + rd_lat < TO_CYC);
        $display("test conv ch %0d done", ch);
    endtask

    // card memory keeps both bytes of every channel
    task automatic test_ram;
        for (int ch = 0; ch < 8; ch++) begin
            bus_read(16'h2100 + 16'(2 * ch), 40);
            chk("ram hi", {ch[0], 5'h00, mags[ch][9:8]}, rd_data);
            bus_read(16'h2101 + 16'(2 * ch), 40);
            chk("ram lo", mags[ch][7:0], rd_data);
        end
        $display("test ram done");
    endtask

    // unmapped reads stay unanswered and never stall
    task automatic test_unmapped(input logic [15:0] addr);
        bus_read(addr, 40);
        chk("no answer", 1'b0, {rd_ack, rd_wait});
        $display("test unmapped %h done", addr);
    endtask

    // frozen clock enable: a pending channel read is neither taken nor started
    task automatic test_freeze;
        int s0;
        s0 = soc_cnt;
        ce = 1'b0;
        bus_addr = 16'h2080;
        bus_rd = 1'b1;
        repeat (10) @(posedge clock);
        #1;
        chk("frozen outs", 16'h0000, {bus_ack_r, bus_wait_r, conv_busy_r});
        chk("frozen start", 16'(s0), 16'(soc_cnt));
        ce = 1'b1;
        $display("test freeze done");
    endtask

    // stalled converter clock: the access bound ends the conversion with zero bits
    task automatic test_stall;
        clk_stop = 1'b1;
        bus_read(16'h2084, TO_CYC + 20);
        chk("stall hi", 16'h0000, rd_data);
        chk("stall latency", 16'(TO_CYC + 2), 16'(rd_lat));
        chk("stall busy", 1'b0, conv_busy_r);
        bus_read(16'h2085, 40);
        chk("stall lo", 16'h0000, rd_data);
        clk_stop = 1'b0;
        $display("test stall done");
    endtask

    // second byte of an idle channel answers at once with last low byte
    task automatic test_idle;
        bus_read(16'h2081, 40);
        chk("idle lo", mags[7][7:0], rd_data);
        chk("idle no wait", 1'b0, rd_wait);
        $display("test idle done");
    endtask

    // =====================================================================
    // run end
    task automatic finish_test;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // watchdog well beyond the expected run length
    initial begin
        repeat (20000) @(posedge clock);
        errors++;
        finish_test;
    end

    // main sequence
    initial begin
        repeat (10) @(posedge clock);
        #1;
        rst = 1'b0;
        @(posedge clock);
        #1;
        chk("reset outs", 16'h0000, {bus_data_r, bus_ack_r, bus_wait_r, mux_sel_r, soc_r, conv_busy_r});
        chk("reset dac", 16'h0000, {dac_neg_r, dac_mag_r});
        $display("test reset done");
        test_freeze;
        for (int ch = 0; ch < 8; ch++) test_conv(ch);
        test_ram;
        test_idle;
        test_stall;
        test_unmapped(16'h2090);
        test_unmapped(16'h3000);
        finish_test;
    end
endmodule // bus_addressed_multichannel_adc_interface_bench
